// file: ssbr_pkg.sv
// Constants, field layouts and carrier types for the scan line, deep
// standby and brightness command registers.
// Assumes a 125 MHz core clock and 16-bit command register addresses.
package ssbr_pkg;

    // Command register addresses
    localparam logic [15:0] ADDR_LINE_HIGH = 16'h4500;
    localparam logic [15:0] ADDR_LINE_LOW = 16'h4501;
    localparam logic [15:0] ADDR_STBY_ENTRY = 16'h4F00;
    localparam logic [15:0] ADDR_BRIGHT_WR_LO = 16'h5100;
    localparam logic [15:0] ADDR_BRIGHT_WR_HI = 16'h5101;
    localparam logic [15:0] ADDR_BRIGHT_RD_LO = 16'h5200;
    localparam logic [15:0] ADDR_BRIGHT_RD_HI = 16'h5201;

    // Field positions and reset values
    localparam int STBY_FLAG_BIT = 0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [11:0] LINE_RESET = 12'h000;

    // Brightness resolution select codes
    localparam logic [1:0] RES_8BIT = 2'h0;
    localparam logic [1:0] RES_10BIT = 2'h1;
    localparam logic [1:0] RES_12BIT = 2'h2;

    // Default frame shape in lines (plain defaults)
    localparam int DEF_SYNC_LINES = 2;
    localparam int DEF_BACK_LINES = 8;
    localparam int DEF_ACTIVE_LINES = 2560;
    localparam int DEF_FRONT_LINES = 16;

    // Deep standby exit: reset pin low for longer than this
    localparam int CLK_MHZ = 125;
    localparam int STBY_EXIT_MS = 3;
    localparam int STBY_EXIT_CYCLES = STBY_EXIT_MS * CLK_MHZ * 1000;
    localparam int EXIT_CNT_W = 20;

    // One command transfer from the host interface
    typedef struct packed {
        logic wr;           // Write strobe
        logic rd;           // Read strobe
        logic [15:0] addr;  // Register address
        logic [7:0] wdata;  // Write parameter byte
    } ssbr_cmd_t;

    // Power state of the block, one-hot
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b01,
        ST_DEEP_STBY = 2'b10
    } ssbr_state_t;

endpackage

// file: ssbr_regs.sv
// Scan line counter, deep standby control and brightness registers.
// Assumes all inputs are synchronous to CLK; LINE_TICK pulses once per
// display line from the timing generator.
module ssbr_regs #(
    parameter int SYNC_LINES = ssbr_pkg::DEF_SYNC_LINES,
    parameter int BACK_LINES = ssbr_pkg::DEF_BACK_LINES,
    parameter int ACTIVE_LINES = ssbr_pkg::DEF_ACTIVE_LINES,
    parameter int FRONT_LINES = ssbr_pkg::DEF_FRONT_LINES,
    parameter int EXIT_CYCLES = ssbr_pkg::STBY_EXIT_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire ssbr_pkg::ssbr_cmd_t CMD,
    input wire logic PARTIAL_MODE,
    input wire logic SW_RESET,
    input wire logic HARDWARE_RESET_N,
    input wire logic LINE_TICK,
    input wire logic [1:0] BRIGHT_RES,
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output logic CMD_REJECT,
    output logic [11:0] CURRENT_LINE_COUNT,
    output logic DEEP_STANDBY_FLAG,
    output logic [15:0] BRIGHTNESS_VALUE,
    output logic [11:0] BRIGHT_LEVEL
);

    // All checks below share this clock and are off during reset
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);

    // Frame length in lines; must fit the 12-bit counter
    localparam int TOTAL_LINES =
        SYNC_LINES + BACK_LINES + ACTIVE_LINES + FRONT_LINES;
    localparam logic [11:0] LAST_LINE = 12'(TOTAL_LINES - 1);
    localparam logic [ssbr_pkg::EXIT_CNT_W-1:0] EXIT_MAX =
        EXIT_CYCLES[ssbr_pkg::EXIT_CNT_W-1:0];

    // Effective brightness level for the selected resolution
    function automatic logic [11:0] ssbr_level(
        input logic [7:0] first_b,
        input logic [7:0] second_b,
        input logic [1:0] res
    );
        logic [11:0] lvl;
        lvl = {4'h0, first_b};
        if (res == ssbr_pkg::RES_10BIT)
        begin
            lvl = {2'h0, first_b[1:0], second_b};
        end
        else if (res == ssbr_pkg::RES_12BIT)
        begin
            lvl = {first_b[3:0], second_b};
        end
        return lvl;
    endfunction

    ssbr_pkg::ssbr_state_t state_q; // Power state
    logic [11:0] line_q;            // Current line in frame
    logic [7:0] bright_lo_q;        // First brightness byte
    logic [7:0] bright_hi_q;        // Second brightness byte
    logic [ssbr_pkg::EXIT_CNT_W-1:0] low_cnt_q; // Reset pin low time
    logic [7:0] rd_data_q;          // Read answer byte
    logic rd_valid_q;               // Read answer strobe
    logic reject_q;                 // Refused command strobe
    logic [11:0] level_q;           // Registered effective level
    logic pin_low;                  // Hardware reset pin asserted
    logic cmd_any;                  // A command is offered
    logic cmd_ok;                   // Command may be taken now
    logic wr_ok;                    // Accepted write
    logic rd_ok;                    // Accepted read
    logic addr_wr_map;              // Address is a writable register
    logic addr_rd_map;              // Address is a readable register
    logic stby_exit;                // Long reset pulse completed
    logic stby_enter;               // Standby entry command accepted

    assign pin_low = !HARDWARE_RESET_N;
    assign cmd_any = CMD.wr || CMD.rd;

    // Commands are refused in partial mode, in deep standby and while
    // the reset pin is held low; the host sees a reject strobe
    assign cmd_ok = !PARTIAL_MODE && !pin_low &&
        (state_q == ssbr_pkg::ST_ACTIVE);
    assign addr_wr_map = (CMD.addr == ssbr_pkg::ADDR_STBY_ENTRY) ||
        (CMD.addr == ssbr_pkg::ADDR_BRIGHT_WR_LO) ||
        (CMD.addr == ssbr_pkg::ADDR_BRIGHT_WR_HI);
    assign addr_rd_map = (CMD.addr == ssbr_pkg::ADDR_LINE_HIGH) ||
        (CMD.addr == ssbr_pkg::ADDR_LINE_LOW) ||
        (CMD.addr == ssbr_pkg::ADDR_BRIGHT_RD_LO) ||
        (CMD.addr == ssbr_pkg::ADDR_BRIGHT_RD_HI);
    // A write wins over a simultaneous read strobe
    assign wr_ok = CMD.wr && cmd_ok && addr_wr_map;
    assign rd_ok = CMD.rd && !CMD.wr && cmd_ok && addr_rd_map;
    assign stby_enter = wr_ok &&
        (CMD.addr == ssbr_pkg::ADDR_STBY_ENTRY) &&
        CMD.wdata[ssbr_pkg::STBY_FLAG_BIT];
    // Exit needs the pin low one cycle beyond the full count
    assign stby_exit = pin_low && (low_cnt_q == EXIT_MAX);

    // Reset pin low-time counter; saturates so long pulses are safe
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            low_cnt_q <= '0;
        end
        else if (CE)
        begin
            if (!pin_low)
            begin
                low_cnt_q <= '0; // Pulse ended, start over
            end
            else if (low_cnt_q != EXIT_MAX)
            begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end
        end
    end

    // Power state machine
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state_q <= ssbr_pkg::ST_ACTIVE;
        end
        else if (CE)
        begin
            unique case (state_q)
                ssbr_pkg::ST_ACTIVE:
                begin
                    if (stby_enter && !SW_RESET)
                    begin
                        state_q <= ssbr_pkg::ST_DEEP_STBY;
                    end
                end
                ssbr_pkg::ST_DEEP_STBY:
                begin
                    // Short reset pulses keep the part asleep
                    if (stby_exit || SW_RESET)
                    begin
                        state_q <= ssbr_pkg::ST_ACTIVE;
                    end
                end
                default:
                begin
                    state_q <= ssbr_pkg::ST_ACTIVE; // Illegal code recovery
                end
            endcase
        end
    end

    // Scan line counter; runs in sleep too, value then not meaningful
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            line_q <= ssbr_pkg::LINE_RESET;
        end
        else if (CE)
        begin
            if (SW_RESET || pin_low)
            begin
                line_q <= ssbr_pkg::LINE_RESET; // Restart at sync line
            end
            else if (LINE_TICK)
            begin
                if (line_q == LAST_LINE)
                begin
                    line_q <= ssbr_pkg::LINE_RESET;
                end
                else
                begin
                    line_q <= line_q + 1'b1;
                end
            end
        end
    end

    // Brightness bytes; any reset source clears them
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            bright_lo_q <= ssbr_pkg::BYTE_RESET;
            bright_hi_q <= ssbr_pkg::BYTE_RESET;
        end
        else if (CE)
        begin
            if (SW_RESET || pin_low)
            begin
                bright_lo_q <= ssbr_pkg::BYTE_RESET;
                bright_hi_q <= ssbr_pkg::BYTE_RESET;
            end
            else if (wr_ok && (CMD.addr == ssbr_pkg::ADDR_BRIGHT_WR_LO))
            begin
                bright_lo_q <= CMD.wdata;
            end
            else if (wr_ok && (CMD.addr == ssbr_pkg::ADDR_BRIGHT_WR_HI))
            begin
                bright_hi_q <= CMD.wdata;
            end
        end
    end

    // Read answer path, one cycle after the command is taken
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            rd_data_q <= ssbr_pkg::BYTE_RESET;
            rd_valid_q <= 1'b0;
            reject_q <= 1'b0;
        end
        else if (CE)
        begin
            rd_valid_q <= rd_ok;
            reject_q <= cmd_any && !(wr_ok || rd_ok);
            if (rd_ok)
            begin
                unique case (CMD.addr)
                    ssbr_pkg::ADDR_LINE_HIGH:
                        rd_data_q <= {4'h0, line_q[11:8]};
                    ssbr_pkg::ADDR_LINE_LOW:
                        rd_data_q <= line_q[7:0];
                    ssbr_pkg::ADDR_BRIGHT_RD_LO:
                        rd_data_q <= bright_lo_q;
                    default:
                        rd_data_q <= bright_hi_q;
                endcase
            end
        end
    end

    // Effective level, registered so the panel side sees a clean value
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            level_q <= ssbr_pkg::LINE_RESET;
        end
        else if (CE)
        begin
            level_q <= ssbr_level(bright_lo_q, bright_hi_q, BRIGHT_RES);
        end
    end

    assign RD_DATA = rd_data_q;
    assign RD_VALID = rd_valid_q;
    assign CMD_REJECT = reject_q;
    assign CURRENT_LINE_COUNT = line_q;
    assign DEEP_STANDBY_FLAG = (state_q == ssbr_pkg::ST_DEEP_STBY);
    assign BRIGHTNESS_VALUE = {bright_hi_q, bright_lo_q};
    assign BRIGHT_LEVEL = level_q;

    // Accepted read of a given address
    sequence seq_read(logic [15:0] a);
        CE && rd_ok && (CMD.addr == a);
    endsequence

    // Accepted write of a given address
    sequence seq_write(logic [15:0] a);
        CE && wr_ok && (CMD.addr == a) && !SW_RESET;
    endsequence

    chk_line_wrap: assert property (
        CE && LINE_TICK && !SW_RESET && !pin_low && (line_q == LAST_LINE)
        |=> (line_q == 12'h000))
        else $error("line count did not wrap to zero");

    chk_line_step: assert property (
        CE && LINE_TICK && !SW_RESET && !pin_low && (line_q != LAST_LINE)
        |=> (line_q == $past(line_q) + 12'h001))
        else $error("line count did not advance");

    chk_line_high: assert property (
        seq_read(ssbr_pkg::ADDR_LINE_HIGH)
        |=> RD_VALID && (RD_DATA == {4'h0, $past(line_q[11:8])}))
        else $error("line high byte wrong");

    chk_line_low: assert property (
        seq_read(ssbr_pkg::ADDR_LINE_LOW)
        |=> RD_VALID && (RD_DATA == $past(line_q[7:0])))
        else $error("line low byte wrong");

    chk_stby_entry: assert property (
        seq_write(ssbr_pkg::ADDR_STBY_ENTRY) ##0 CMD.wdata[0]
        |=> DEEP_STANDBY_FLAG)
        else $error("deep standby not entered");

    chk_stby_exit: assert property (
        $fell(DEEP_STANDBY_FLAG)
        |-> $past(stby_exit) || $past(SW_RESET))
        else $error("deep standby left without long reset");

    chk_stby_hold: assert property (
        CE && DEEP_STANDBY_FLAG && !stby_exit && !SW_RESET
        |=> DEEP_STANDBY_FLAG)
        else $error("deep standby left early");

    chk_bright_wr: assert property (
        seq_write(ssbr_pkg::ADDR_BRIGHT_WR_HI)
        |=> (BRIGHTNESS_VALUE[15:8] == $past(CMD.wdata)))
        else $error("brightness high byte not stored");

    chk_bright_rd: assert property (
        seq_read(ssbr_pkg::ADDR_BRIGHT_RD_LO)
        |=> RD_VALID && (RD_DATA == $past(bright_lo_q)))
        else $error("brightness low byte read wrong");

    chk_level_10: assert property (
        CE && (BRIGHT_RES == ssbr_pkg::RES_10BIT)
        |=> (BRIGHT_LEVEL == {2'h0, $past(bright_lo_q[1:0]),
            $past(bright_hi_q)}))
        else $error("ten bit level wrong");

    chk_level_12: assert property (
        CE && (BRIGHT_RES == ssbr_pkg::RES_12BIT)
        |=> (BRIGHT_LEVEL == {$past(bright_lo_q[3:0]), $past(bright_hi_q)}))
        else $error("twelve bit level wrong");

    chk_partial_ref: assert property (
        CE && cmd_any && PARTIAL_MODE && !SW_RESET && !pin_low
        |=> CMD_REJECT && !RD_VALID && $stable(BRIGHTNESS_VALUE))
        else $error("command taken in partial mode");

    chk_reset_clear: assert property (
        CE && SW_RESET
        |=> (BRIGHTNESS_VALUE == 16'h0000) && !DEEP_STANDBY_FLAG)
        else $error("software reset did not clear state");

endmodule // ssbr_regs

// file: ssbr_host.sv
// Host processor model: issues command register transfers and drives the
// hardware reset pin. Assumes the block samples on the rising clk edge.
module ssbr_host (
    input wire logic clk,
    output ssbr_pkg::ssbr_cmd_t cmd,
    output logic hw_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus and released reset pin from time zero
    initial
    begin
        cmd = '0;
        hw_reset_n = 1'b1;
    end

    // One transfer: strobe held for exactly one sampling edge, then idle.
    task automatic xfer(input logic wr, input logic [15:0] addr,
                        input logic [7:0] data);
        @(posedge clk);
        cmd <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
        @(posedge clk);
        cmd <= '0;
        #1;
    endtask

    // Pull the reset pin low for a number of sampled cycles
    task automatic pin_low(input int cycles);
        @(posedge clk);
        hw_reset_n <= 1'b0;
        repeat (cycles) @(posedge clk);
        #1;
    endtask

    // Release the reset pin
    task automatic pin_high();
        @(posedge clk);
        hw_reset_n <= 1'b1;
        #1;
    endtask
endmodule // ssbr_host

// file: testbench.sv
// Self-checking bench for the scan line, standby and brightness registers.
// Assumes a shortened frame (303 lines) and a 20-cycle standby exit count.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int EXIT_N = 20; // Short exit count keeps the run brief
    localparam int TOTAL = 303; // 1 sync + 1 back + 300 active + 1 front

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1; // Clock enable, lowered once to show freezing
    logic partial_mode = 1'b0; // Partial display mode request
    logic sw_reset = 1'b0;
    logic line_tick = 1'b0;
    logic [1:0] bright_res = 2'h0;
    logic [7:0] rd_data;
    logic rd_valid;
    logic cmd_reject;
    logic [11:0] line_count;
    logic stby_flag;
    logic [15:0] bright_val;
    logic [11:0] bright_level;
    ssbr_pkg::ssbr_cmd_t cmd;
    logic hw_reset_n;
    int bad_count = 0;
    int comparisons = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    ssbr_host u_host (.clk(clk), .cmd(cmd), .hw_reset_n(hw_reset_n));

    // Small frame and short exit count keep the run brief
    ssbr_regs #(.SYNC_LINES(1), .BACK_LINES(1), .ACTIVE_LINES(300),
        .FRONT_LINES(1), .EXIT_CYCLES(EXIT_N)) u_dut (
        .CLK(clk), .RST(rst), .CE(ce), .CMD(cmd),
        .PARTIAL_MODE(partial_mode), .SW_RESET(sw_reset),
        .HARDWARE_RESET_N(hw_reset_n), .LINE_TICK(line_tick),
        .BRIGHT_RES(bright_res), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .CMD_REJECT(cmd_reject), .CURRENT_LINE_COUNT(line_count),
        .DEEP_STANDBY_FLAG(stby_flag), .BRIGHTNESS_VALUE(bright_val),
        .BRIGHT_LEVEL(bright_level));

    // Single comparison point; four-state compare so X never matches
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    // Read one register; the answer stands only in the following cycle
    task automatic read_chk(input logic [15:0] addr, input logic [7:0] exp);
        u_host.xfer(1'b0, addr, 8'h00);
        check({15'h0000, rd_valid}, 16'h0001, "read valid");
        check({8'h00, rd_data}, {8'h00, exp}, "read data");
    endtask

    // A refused command pulses the reject strobe and returns nothing
    task automatic reject_chk(input logic wr, input logic [15:0] addr);
        u_host.xfer(wr, addr, 8'h5A);
        check({15'h0000, cmd_reject}, 16'h0001, "reject");
        check({15'h0000, rd_valid}, 16'h0000, "no answer");
    endtask

    // Hold the line tick for n consecutive sampling edges
    task automatic tick(input int n);
        @(posedge clk);
        line_tick <= 1'b1;
        repeat (n) @(posedge clk);
        line_tick <= 1'b0;
        #1;
    endtask

    // Power-on defaults, then a software reset after a write
    task automatic t_resets();
        check(bright_val, 16'h0000, "bright default");
        check({15'h0000, stby_flag}, 16'h0000, "flag default");
        read_chk(16'h5201, 8'h00);
        u_host.xfer(1'b1, 16'h5101, 8'hAA);
        @(posedge clk);
        sw_reset <= 1'b1;
        @(posedge clk);
        sw_reset <= 1'b0;
        #1;
        check(bright_val, 16'h0000, "after sw reset");
    endtask

    // Byte order on write and read, and the level for every resolution
    task automatic t_bright();
        logic [15:0] lv[4] = '{16'h0037, 16'h03C5, 16'h07C5, 16'h0037};
        u_host.xfer(1'b1, 16'h5100, 8'h37);
        u_host.xfer(1'b1, 16'h5101, 8'hC5);
        check(bright_val, 16'hC537, "bright value");
        read_chk(16'h5200, 8'h37);
        read_chk(16'h5201, 8'hC5);
        for (int r = 0; r < 4; r++)
        begin
            @(posedge clk);
            bright_res <= r[1:0];
            repeat (2) @(posedge clk);
            #1;
            check({4'h0, bright_level}, lv[r], "level");
        end
    endtask

    // Wrong-direction, unmapped and partial-mode commands change nothing
    task automatic t_refuse();
        logic [16:0] tbl[5] = '{{1'b1, 16'h4500}, {1'b1, 16'h5201},
            {1'b0, 16'h4F00}, {1'b0, 16'h5101}, {1'b0, 16'h1234}};
        foreach (tbl[i])
            reject_chk(tbl[i][16], tbl[i][15:0]);
        @(posedge clk);
        partial_mode <= 1'b1;
        reject_chk(1'b1, 16'h5100);
        reject_chk(1'b0, 16'h5200);
        check(bright_val, 16'hC537, "kept in partial");
        @(posedge clk);
        partial_mode <= 1'b0;
    endtask

    // Count 0x102 lines to show the nibble split, then wrap at frame end
    task automatic t_lines();
        tick(258);
        read_chk(16'h4500, 8'h01);
        read_chk(16'h4501, 8'h02);
        tick(TOTAL - 259);
        check({4'h0, line_count}, 16'(TOTAL - 1), "last line");
        // Ticks while the clock enable is low must not move the count
        @(posedge clk);
        ce <= 1'b0;
        tick(3);
        check({4'h0, line_count}, 16'(TOTAL - 1), "frozen");
        @(posedge clk);
        ce <= 1'b1;
        tick(1);
        check({4'h0, line_count}, 16'h0000, "wrap to zero");
    endtask

    // Entry only with bit zero set; exit after a long pin pulse or a software reset
    task automatic t_standby();
        u_host.xfer(1'b1, 16'h4F00, 8'h00);
        check({15'h0000, stby_flag}, 16'h0000, "flag clear");
        u_host.xfer(1'b1, 16'h4F00, 8'h01);
        check({15'h0000, stby_flag}, 16'h0001, "flag set");
        reject_chk(1'b0, 16'h5200);
        u_host.pin_low(EXIT_N);
        check({15'h0000, stby_flag}, 16'h0001, "short pulse");
        check(bright_val, 16'h0000, "pin clears");
        @(posedge clk);
        #1;
        check({15'h0000, stby_flag}, 16'h0000, "exit");
        u_host.pin_high();
        // Software reset also leaves deep standby
        u_host.xfer(1'b1, 16'h4F00, 8'h01);
        check({15'h0000, stby_flag}, 16'h0001, "set again");
        @(posedge clk);
        sw_reset <= 1'b1;
        @(posedge clk);
        sw_reset <= 1'b0;
        #1;
        check({15'h0000, stby_flag}, 16'h0000, "sw reset exit");
    endtask

    // Verdict and end of run
    task automatic final_report();
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_resets();
        t_bright();
        t_refuse();
        t_lines();
        t_standby();
        final_report();
    end

    // Watchdog: the tests need well under 2000 cycles
    initial
    begin
        #50000;
        bad_count++;
        $display("ERROR t=%0t watchdog expired", $time);
        final_report();
    end
endmodule // testbench
